// ===== verilog/pcmh_top.sv
`include "pcmh_consts.svh"
module pcmh_top #(
  parameter int NUM_CODES = `PCMH_NUM_CODES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        plc_axes_hold_n,
  input  wire logic        plc_block_transfer_inhibit_n,
  input  wire logic        plc_aux_function_done,
  input  wire logic        plc_block_abort,
  input  wire logic        magazine_return_busy_n,
  input  wire logic        decel_done,
  output logic             plc_aux_function_strobe,
  output logic             plc_axes_motion_enable,
  output logic             spindle_run,
  output logic             block_active,
  output logic             block_abort_ack,
  output logic             next_target_prepared_only
);

  typedef struct packed {
    logic                         auto_mode;
    logic                         sim_mode;
    logic [2:0]                   blk_type;
    logic                         aux_after;
    logic                         start_pend;
    logic                         aux_pend;
    logic [15:0]                  ack_time;
    logic [NUM_CODES-1:0][31:0]   codes;
    pcmh_pkg::pcmh_aux_state_type aux_st;
    pcmh_pkg::pcmh_blk_state_type blk_st;
    logic [15:0]                  ack_cnt;
    logic                         hold_s;
    logic                         inh_s;
    logic                         done_s;
    logic                         abort_s;
    logic                         mag_s;
    logic                         abort_req;
    logic                         aborted;
    logic                         strobe;
    logic                         motion_en;
    logic                         blk_act;
    logic                         abort_ack;
    logic                         wr_pend;
    logic                         rd_pend;
    logic [7:0]                   addr;
    logic [31:0]                  rdata;
    logic [15:0]                  blocks_done;
    logic                         ready_out;
    logic                         resp_err;
  } pcmh_state_type;

  pcmh_state_type q;
  pcmh_state_type d;

  function automatic logic abortable(input logic [2:0] t);
    abortable = (t == `PCMH_BT_LINEAR) || (t == `PCMH_BT_DWELL) || (t == `PCMH_BT_SPINPOS);
  endfunction

  // Aligned word inside the code window
  function automatic logic is_code_addr(input logic [7:0] a);
    is_code_addr = (a >= `PCMH_CODE0_OFF) && (a <= `PCMH_CODE_LAST_OFF) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [2:0] code_index(input logic [7:0] a);
    logic [7:0] off;
    off = a - `PCMH_CODE0_OFF;
    code_index = off[4:2];
  endfunction

  function automatic logic [15:0] count_up(input logic [15:0] c);
    count_up = c + 16'h0001;
  endfunction

  // Where a block goes once its motion has ended or been cut
  function automatic pcmh_pkg::pcmh_blk_state_type end_state(input logic aux_after);
    end_state = aux_after ? pcmh_pkg::PCMH_BLK_AUX : pcmh_pkg::PCMH_BLK_IDLE;
  endfunction

  function automatic logic [31:0] reg_read(input pcmh_state_type s, input logic [7:0] a);
    // Unmapped offsets read as zero
    reg_read = 32'h0000_0000;
    case (a)
      `PCMH_CTRL_OFF: begin
        reg_read = {21'h00000, s.blk_type, 3'h0, s.aux_after, s.aux_pend, s.start_pend,
                    s.sim_mode, s.auto_mode};
      end
      `PCMH_STAT_OFF: begin
        reg_read = {s.blocks_done, 8'h00, s.aborted, s.abort_req, s.mag_s, s.inh_s,
                    s.hold_s, s.strobe, s.blk_act, s.motion_en};
      end
      `PCMH_ACKTIME_OFF: begin
        reg_read = {16'h0000, s.ack_time};
      end
      default: begin
        if (is_code_addr(a)) begin
          reg_read = s.codes[code_index(a)];
        end
      end
    endcase
  endfunction

  always_comb begin
    d = q;
    d.abort_ack = 1'b0;
    // Zero wait states, OKAY only
    d.ready_out = 1'b1;
    d.resp_err  = 1'b0;
    // Inputs registered once per clock
    d.hold_s  = plc_axes_hold_n;
    d.inh_s   = plc_block_transfer_inhibit_n;
    d.done_s  = plc_aux_function_done;
    d.abort_s = plc_block_abort;
    d.mag_s   = magazine_return_busy_n;

    // AHB-Lite data phase
    if (q.wr_pend) begin
      case (q.addr)
        `PCMH_CTRL_OFF: begin
          d.auto_mode = hwdata[`PCMH_CTRL_AUTO_BIT];
          d.sim_mode  = hwdata[`PCMH_CTRL_SIM_BIT];
          d.aux_after = hwdata[`PCMH_CTRL_AUXAFT_BIT];
          d.blk_type  = hwdata[`PCMH_CTRL_TYPE_MSB:`PCMH_CTRL_TYPE_LSB];
          if (hwdata[`PCMH_CTRL_START_BIT]) begin
            d.start_pend = 1'b1;
          end
          if (hwdata[`PCMH_CTRL_AUXREQ_BIT]) begin
            d.aux_pend = 1'b1;
          end
        end
        `PCMH_ACKTIME_OFF: begin
          d.ack_time = hwdata[15:0];
        end
        default: begin
          if (is_code_addr(q.addr)) begin
            d.codes[code_index(q.addr)] = hwdata;
          end
        end
      endcase
    end
    d.wr_pend = 1'b0;
    d.rd_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      d.addr    = {haddr[7:2], 2'b00};
      d.wr_pend = hwrite;
      d.rd_pend = !hwrite;
      d.rdata   = reg_read(q, {haddr[7:2], 2'b00});
    end

    // Axis hold gates PLC axis motion only
    d.motion_en = (q.blk_st == pcmh_pkg::PCMH_BLK_MOVE) && q.hold_s;

    // Abort request latch; honoured only in auto or sim mode
    if (q.abort_s && (q.auto_mode || q.sim_mode)) begin
      d.abort_req = 1'b1;
    end

    case (q.blk_st)
      pcmh_pkg::PCMH_BLK_IDLE: begin
        d.blk_act = 1'b0;
        if (d.abort_req) begin
          d.abort_req = 1'b0;
        end
        if (q.start_pend && q.inh_s) begin
          d.start_pend = 1'b0;
          d.blk_act    = 1'b1;
          d.aborted    = 1'b0;
          d.blk_st     = pcmh_pkg::PCMH_BLK_MOVE;
        end
      end
      pcmh_pkg::PCMH_BLK_MOVE: begin
        // Abort wins over normal completion
        if (q.abort_req && !abortable(q.blk_type)) begin
          d.abort_req = 1'b0;
        end else if (q.abort_req && abortable(q.blk_type) && decel_done) begin
          d.abort_req = 1'b0;
          d.abort_ack = 1'b1;
          d.aborted   = 1'b1;
          d.motion_en = 1'b0;
          d.blk_st    = end_state(q.aux_after);
          d.blocks_done = q.aux_after ? q.blocks_done : count_up(q.blocks_done);
        end else if (decel_done && q.motion_en) begin
          // Block ran out on its own
          d.motion_en   = 1'b0;
          d.blk_st      = end_state(q.aux_after);
          d.blocks_done = q.aux_after ? q.blocks_done : count_up(q.blocks_done);
        end
      end
      pcmh_pkg::PCMH_BLK_AUX: begin
        d.abort_req = 1'b0;
        if (q.aux_st == pcmh_pkg::PCMH_IDLE && !q.aux_pend) begin
          d.aux_pend = 1'b1;
        end
      end
      default: begin
        d.blk_st = pcmh_pkg::PCMH_BLK_IDLE;
      end
    endcase

    // Aux function strobe/done handshake
    case (q.aux_st)
      pcmh_pkg::PCMH_IDLE: begin
        d.ack_cnt = 16'h0000;
        if (q.aux_pend) begin
          d.aux_pend = 1'b0;
          d.strobe   = 1'b1;
          d.aux_st   = pcmh_pkg::PCMH_WAIT_DONE_LOW;
        end
      end
      pcmh_pkg::PCMH_WAIT_DONE_LOW: begin
        if (!q.done_s) begin
          d.aux_st = pcmh_pkg::PCMH_WAIT_DONE_HIGH;
        end
      end
      pcmh_pkg::PCMH_WAIT_DONE_HIGH: begin
        d.ack_cnt = 16'h0000;
        if (q.done_s) begin
          d.aux_st = pcmh_pkg::PCMH_HOLD_CHECK;
        end
      end
      pcmh_pkg::PCMH_HOLD_CHECK: begin
        // Done dropping during the hold restarts the count
        if (!q.done_s) begin
          d.ack_cnt = 16'h0000;
          d.aux_st  = pcmh_pkg::PCMH_WAIT_DONE_HIGH;
        end else if (q.ack_cnt > q.ack_time) begin
          d.strobe = 1'b0;
          d.aux_st = pcmh_pkg::PCMH_IDLE;
        end else begin
          d.ack_cnt = count_up(q.ack_cnt);
        end
      end
      default: begin
        d.aux_st = pcmh_pkg::PCMH_IDLE;
      end
    endcase
    // Handshake over: the waiting block may finish now
    if (q.blk_st == pcmh_pkg::PCMH_BLK_AUX && q.aux_st == pcmh_pkg::PCMH_HOLD_CHECK &&
        d.aux_st == pcmh_pkg::PCMH_IDLE) begin
      d.aux_pend    = 1'b0;
      d.blk_st      = pcmh_pkg::PCMH_BLK_IDLE;
      d.blocks_done = count_up(q.blocks_done);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q          <= '0;
      q.ack_time <= 16'(`PCMH_MIN_ACK_CYC);
      q.ready_out <= 1'b1;
      q.hold_s   <= 1'b1;
      q.inh_s    <= 1'b1;
      q.done_s   <= 1'b1;
      q.mag_s    <= 1'b1;
      q.aux_st   <= pcmh_pkg::PCMH_IDLE;
      q.blk_st   <= pcmh_pkg::PCMH_BLK_IDLE;
    end else begin
      q <= d;
    end
  end

  assign hrdata                    = q.rdata;
  assign hreadyout                 = q.ready_out;
  assign hresp                     = q.resp_err;
  assign plc_aux_function_strobe   = q.strobe;
  assign plc_axes_motion_enable    = q.motion_en;
  assign spindle_run               = q.blk_act;
  assign block_active              = q.blk_act;
  assign block_abort_ack           = q.abort_ack;
  assign next_target_prepared_only = q.aborted;

endmodule

// ===== verilog/pcmh_consts.svh
`ifndef PCMH_CONSTS_SVH
`define PCMH_CONSTS_SVH
// Register byte offsets
`define PCMH_CTRL_OFF        8'h00
`define PCMH_STAT_OFF        8'h04
`define PCMH_AUXCODE_OFF     8'h08
`define PCMH_ACKTIME_OFF     8'h0C
`define PCMH_CODE0_OFF       8'h10
`define PCMH_CODE_LAST_OFF   8'h28
// CTRL fields
`define PCMH_CTRL_AUTO_BIT   0
`define PCMH_CTRL_SIM_BIT    1
`define PCMH_CTRL_START_BIT  2
`define PCMH_CTRL_AUXREQ_BIT 3
`define PCMH_CTRL_AUXAFT_BIT 4
`define PCMH_CTRL_TYPE_LSB   8
`define PCMH_CTRL_TYPE_MSB   10
// Block types
`define PCMH_BT_NOMOTION     3'h0
`define PCMH_BT_LINEAR       3'h1
`define PCMH_BT_DWELL        3'h2
`define PCMH_BT_THREAD       3'h3
`define PCMH_BT_TAP          3'h4
`define PCMH_BT_SPINPOS      3'h5
// Timing
`define PCMH_MIN_ACK_NS      1000
`define PCMH_CLK_NS          10
`define PCMH_MIN_ACK_CYC     ((`PCMH_MIN_ACK_NS + `PCMH_CLK_NS - 1) / `PCMH_CLK_NS)
`define PCMH_NUM_CODES       7
`endif

// ===== verilog/pcmh_pkg.sv
package pcmh_pkg;
  typedef enum logic [2:0] {
    PCMH_IDLE,
    PCMH_RUN,
    PCMH_WAIT_DONE_LOW,
    PCMH_WAIT_DONE_HIGH,
    PCMH_HOLD_CHECK
  } pcmh_aux_state_type;

  typedef enum logic [1:0] {
    PCMH_BLK_IDLE,
    PCMH_BLK_MOVE,
    PCMH_BLK_AUX
  } pcmh_blk_state_type;
endpackage

// ===== test/pcmh_top_properties.sv
`include "pcmh_consts.svh"
module pcmh_top_properties #(
  parameter int NUM_CODES = `PCMH_NUM_CODES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic plc_axes_hold_n,
  input wire logic plc_block_transfer_inhibit_n,
  input wire logic plc_aux_function_done,
  input wire logic decel_done,
  input wire logic plc_aux_function_strobe,
  input wire logic plc_axes_motion_enable,
  input wire logic spindle_run,
  input wire logic block_active,
  input wire logic block_abort_ack,
  input wire logic next_target_prepared_only
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  chk_hold_stops: assert property ((!plc_axes_hold_n)[*3] |-> !plc_axes_motion_enable)
    else $error("axes still moving during hold");
  chk_spindle_turns: assert property (spindle_run == block_active)
    else $error("spindle does not follow block");
  chk_inhibit_start: assert property (
    (!plc_block_transfer_inhibit_n)[*3] |-> !$rose(block_active))
    else $error("block started while inhibited");
  chk_min_hold: assert property ($fell(plc_aux_function_strobe) |->
    $past(plc_aux_function_done) && $past(plc_aux_function_done, 2) &&
    $past(plc_aux_function_done, 3)) else $error("strobe dropped too early");
  // Bound assumes an acknowledge time of 3 cycles
  chk_strobe_release: assert property ($rose(plc_aux_function_done) ##1
    plc_aux_function_done[*7] |=> !plc_aux_function_strobe) else $error("strobe held");
  chk_ack_pulse: assert property (block_abort_ack |=> !block_abort_ack)
    else $error("abort ack longer than one cycle");
  chk_abort_decel: assert property (block_abort_ack |-> $past(decel_done) ||
    $past(decel_done, 2) || $past(decel_done, 3)) else $error("abort before decel");
  chk_abort_target: assert property (
    $rose(block_abort_ack) |-> ##[0:2] next_target_prepared_only)
    else $error("prepared target flag missing");
endmodule
bind pcmh_top pcmh_top_properties #(.NUM_CODES(NUM_CODES)) u_props (
  .hclk, .hresetn, .plc_axes_hold_n, .plc_block_transfer_inhibit_n, .plc_aux_function_done,
  .decel_done, .plc_aux_function_strobe, .plc_axes_motion_enable, .spindle_run,
  .block_active, .block_abort_ack, .next_target_prepared_only
);

// ===== test/pcmh_plc_model.sv
module pcmh_plc_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       plc_aux_function_strobe,
  input  wire logic [3:0] work,
  output logic            plc_aux_function_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       served_q;
  logic [3:0] cnt_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      plc_aux_function_done <= 1'b1;
      served_q <= 1'b0;
      cnt_q <= 4'h0;
    end else if (!plc_aux_function_strobe) begin
      served_q <= 1'b0;
    end else if (!served_q && plc_aux_function_done) begin
      plc_aux_function_done <= 1'b0;
      cnt_q <= work;
    end else if (!plc_aux_function_done && cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (!plc_aux_function_done) begin
      // Done then held high until the next strobe starts a new request
      plc_aux_function_done <= 1'b1;
      served_q <= 1'b1;
    end
  end
endmodule

// ===== test/test_plc_channel_motion_handshake.sv
`include "pcmh_consts.svh"
module test_plc_channel_motion_handshake;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        hold_n = 1'b1, inh_n = 1'b1, abort = 1'b0, mag_n = 1'b1, decel = 1'b0;
  logic        seen_ack = 1'b0, seen_strobe = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [7:0]  haddr = 8'h00;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic [3:0]  work = 4'h1;
  logic        hreadyout, hresp, done, strobe, motion, spindle, active, ack, prep;
  int          fail_count = 0, checks_done = 0;
  pcmh_top #(.NUM_CODES(`PCMH_NUM_CODES)) uut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .plc_axes_hold_n(hold_n), .plc_block_transfer_inhibit_n(inh_n),
    .plc_aux_function_done(done), .plc_block_abort(abort), .magazine_return_busy_n(mag_n),
    .decel_done(decel), .plc_aux_function_strobe(strobe), .plc_axes_motion_enable(motion),
    .spindle_run(spindle), .block_active(active), .block_abort_ack(ack),
    .next_target_prepared_only(prep));
  pcmh_plc_model plc (.hclk, .hresetn, .plc_aux_function_strobe(strobe), .work,
    .plc_aux_function_done(done));
  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    if (ack === 1'b1) seen_ack <= 1'b1;
    if (strobe === 1'b1) seen_strobe <= 1'b1;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_on(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 300) begin
      @(posedge hclk);
      n++;
    end
    if (s !== v) begin
      chk(s, v);
      wrap_up();
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    wait_on(hreadyout, 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    wait_on(hreadyout, 1'b1);
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic t_regs;
    rdc(`PCMH_ACKTIME_OFF, 32'hFFFF, 32'(`PCMH_MIN_ACK_CYC));
    ahb(1'b1, `PCMH_ACKTIME_OFF, 32'h3);
    rdc(`PCMH_ACKTIME_OFF, 32'hFFFF, 32'h3);
    ahb(1'b1, `PCMH_CODE_LAST_OFF, 32'hA5A5_0007);
    rdc(`PCMH_CODE_LAST_OFF, 32'hFFFF_FFFF, 32'hA5A5_0007);
    rdc(8'h40, 32'hFFFF_FFFF, 32'h0);
    mag_n <= 1'b0;
    repeat (4) @(posedge hclk);
    rdc(`PCMH_STAT_OFF, 32'h20, 32'h0);
    mag_n <= 1'b1;
    repeat (4) @(posedge hclk);
    rdc(`PCMH_STAT_OFF, 32'h20, 32'h20);
    $display("test regs finished");
  endtask
  task automatic t_aux(input logic [3:0] w);
    work <= w;
    ahb(1'b1, `PCMH_CTRL_OFF, 32'h8);
    wait_on(strobe, 1'b1);
    wait_on(strobe, 1'b0);
    chk(done, 1'b1);
    $display("test aux finished");
  endtask
  task automatic t_hold;
    inh_n <= 1'b0;
    ahb(1'b1, `PCMH_CTRL_OFF, 32'h105);
    repeat (10) @(posedge hclk);
    chk(active, 1'b0);
    inh_n <= 1'b1;
    wait_on(active, 1'b1);
    repeat (3) @(posedge hclk);
    chk(motion, 1'b1);
    hold_n <= 1'b0;
    repeat (4) @(posedge hclk);
    chk(motion, 1'b0);
    chk(spindle, 1'b1);
    hold_n <= 1'b1;
    repeat (4) @(posedge hclk);
    chk(motion, 1'b1);
    inh_n <= 1'b0;
    decel <= 1'b1;
    wait_on(active, 1'b0);
    decel <= 1'b0;
    inh_n <= 1'b1;
    $display("test hold finished");
  endtask
  task automatic t_abort;
    logic [11:0] tab [9];
    tab = '{12'h901, 12'hA01, 12'h902, 12'h911, 12'h001, 12'h301, 12'h401, 12'h100,
            12'hD01};
    for (int i = 0; i < 9; i++) begin
      seen_ack <= 1'b0;
      seen_strobe <= 1'b0;
      ahb(1'b1, `PCMH_CTRL_OFF, {21'h0, tab[i][10:0]} | 32'h4);
      wait_on(active, 1'b1);
      abort <= 1'b1;
      repeat (2) @(posedge hclk);
      decel <= 1'b1;
      repeat (20) @(posedge hclk);
      chk(seen_ack, tab[i][11]);
      if (tab[i][11]) chk(prep, 1'b1);
      abort <= 1'b0;
      wait_on(active, 1'b0);
      repeat (8) @(posedge hclk);
      wait_on(strobe, 1'b0);
      decel <= 1'b0;
      chk(seen_strobe, tab[i][4]);
      rdc(`PCMH_STAT_OFF, 32'h40, 32'h0);
    end
    rdc(`PCMH_STAT_OFF, 32'hFFFF_0000, 32'h000A_0000);
    $display("test abort finished");
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_aux(4'h1);
    t_aux(4'h9);
    t_hold();
    t_abort();
    wrap_up();
  end
endmodule
